// *** verilog/uhic_regs.svh ***
// Register offsets, field positions, reset values and vector constants of the interrupt controller
`ifndef UHIC_REGS_SVH
`define UHIC_REGS_SVH

// Register offsets on the plain register port
`define UHIC_GMASK_OFS      8'h20
`define UHIC_EMASK_OFS      8'h21
`define UHIC_AMASK_OFS      8'h22
`define UHIC_PSTAT_OFS      8'hFF

// Implemented bits of each mask register
`define UHIC_GMASK_WMASK    8'h6F
`define UHIC_EMASK_WMASK    8'h1F
`define UHIC_AMASK_WMASK    8'h01
`define UHIC_MASK_RST       8'h00
`define UHIC_RDATA_RST      8'h00

// Global mask fields
`define UHIC_G_BUSRST_BIT   0
`define UHIC_G_T128_BIT     1
`define UHIC_G_T1024_BIT    2
`define UHIC_G_HUB_BIT      3
`define UHIC_G_GPIO_BIT     5
`define UHIC_G_SERIAL_BIT   6

// Endpoint mask fields
`define UHIC_E_A0_BIT       0
`define UHIC_E_A1_BIT       1
`define UHIC_E_A2_BIT       2
`define UHIC_E_B0_BIT       3
`define UHIC_E_B1_BIT       4

// Auxiliary mask field
`define UHIC_A_CONV_BIT     0

// Status fields
`define UHIC_PSTAT_PEND_BIT 7
`define UHIC_PSTAT_SENS_BIT 2

// Source indices, in priority order (index 0 wins)
`define UHIC_SRC_BUSRST     0
`define UHIC_SRC_T128       1
`define UHIC_SRC_T1024      2
`define UHIC_SRC_A0         3
`define UHIC_SRC_A1         4
`define UHIC_SRC_A2         5
`define UHIC_SRC_B0         6
`define UHIC_SRC_B1         7
`define UHIC_SRC_HUB        8
`define UHIC_SRC_CONV       9
`define UHIC_SRC_GPIO       10
`define UHIC_SRC_SERIAL     11
`define UHIC_NUM_SRC        12

// Vector table
`define UHIC_RESET_VEC      16'h0000
`define UHIC_VEC_STEP       16'h0002

`endif

// *** verilog/uhic_pkg.sv ***
// Types shared by the interrupt controller files
`default_nettype none
package uhic_pkg;

	// Processor context saved by the automatic call and restored on return
	typedef struct packed {
		logic [15:0] pc;
		logic        carry_flag;
		logic        zero_flag;
	} uhic_frame_s;

	// Sequencer states
	typedef enum logic [0:0] {
		UHIC_BOOT,
		UHIC_RUN
	} uhic_state_e;

endpackage
`default_nettype wire

// *** verilog/uhic_pend_latch.sv ***
// One pending-request latch per interrupt source
`timescale 1ns/1ps
`default_nettype none
module uhic_pend_latch
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      pend_o
);

	logic pend_reg;

	// Event sets, service clears; a set in the clearing cycle wins
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			pend_reg <= 1'b0;
		else if (set_i)
			pend_reg <= 1'b1;
		else if (clr_i)
			pend_reg <= 1'b0;
	end

	assign pend_o = pend_reg;

endmodule
`default_nettype wire

// *** verilog/uhic_irq_ctrl.sv ***
// Interrupt controller of the hub microcontroller: masks, latches, priority, call and return
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "uhic_regs.svh"
module uhic_irq_ctrl
#(
	parameter int NUM_SRC = `UHIC_NUM_SRC
)
(
	input  wire logic                 clk_i,
	input  wire logic                 nrst_i,
	// Register port
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [7:0]           reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [7:0]           reg_rdata_o,
	// Event pulses from the on-chip sources, priority order
	input  wire logic [NUM_SRC-1:0]   src_event_i,
	// Processor side
	input  wire logic                 instr_done_i,
	input  wire logic                 unmask_all_irq_op_i,
	input  wire logic                 mask_all_irq_op_i,
	input  wire logic                 irq_return_op_i,
	input  wire uhic_pkg::uhic_frame_s cpu_frame_i,
	input  wire uhic_pkg::uhic_frame_s stack_frame_i,
	output logic                      boot_start_o,
	output logic                      irq_call_o,
	output logic      [15:0]          irq_vector_o,
	output uhic_pkg::uhic_frame_s     push_frame_o,
	output logic                      restore_o,
	output uhic_pkg::uhic_frame_s     restore_frame_o,
	output logic                      global_irq_en_o,
	output logic                      irq_pending_o
);

	uhic_pkg::uhic_state_e state_reg;
	uhic_pkg::uhic_state_e state_next;

	logic [7:0]         global_irq_mask_reg;
	logic [7:0]         endpoint_irq_mask_reg;
	logic [7:0]         aux_irq_mask_reg;
	logic               global_en_reg;
	logic               global_en_next;
	logic [7:0]         rdata_reg;
	logic [7:0]         rdata_next;
	logic               boot_reg;
	logic               call_reg;
	logic [15:0]        vector_reg;
	logic [15:0]        vector_next;
	uhic_pkg::uhic_frame_s push_frame_reg;
	logic               restore_reg;
	uhic_pkg::uhic_frame_s restore_frame_reg;
	logic               pending_reg;

	logic [NUM_SRC-1:0] enable_vec;
	logic [NUM_SRC-1:0] pend_vec;
	logic [NUM_SRC-1:0] req_vec;
	logic [NUM_SRC-1:0] win_vec;
	logic [NUM_SRC-1:0] clr_vec;
	logic               any_req;
	logic               take;
	logic               wr_gmask;
	logic               wr_emask;
	logic               wr_amask;

	// Write decode
	assign wr_gmask = reg_wr_i && (reg_addr_i == `UHIC_GMASK_OFS);
	assign wr_emask = reg_wr_i && (reg_addr_i == `UHIC_EMASK_OFS);
	assign wr_amask = reg_wr_i && (reg_addr_i == `UHIC_AMASK_OFS);

	// Global mask register, reserved bits held at zero
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			global_irq_mask_reg <= `UHIC_MASK_RST;
		else if (wr_gmask)
			global_irq_mask_reg <= reg_wdata_i & `UHIC_GMASK_WMASK;
	end

	// Endpoint mask register, reserved bits held at zero
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			endpoint_irq_mask_reg <= `UHIC_MASK_RST;
		else if (wr_emask)
			endpoint_irq_mask_reg <= reg_wdata_i & `UHIC_EMASK_WMASK;
	end

	// Auxiliary mask register for the converter source
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			aux_irq_mask_reg <= `UHIC_MASK_RST;
		else if (wr_amask)
			aux_irq_mask_reg <= reg_wdata_i & `UHIC_AMASK_WMASK;
	end

	// Map mask bits onto sources in priority order
	always_comb
	begin
		enable_vec = '0;
		enable_vec[`UHIC_SRC_BUSRST] = global_irq_mask_reg[`UHIC_G_BUSRST_BIT];
		enable_vec[`UHIC_SRC_T128]   = global_irq_mask_reg[`UHIC_G_T128_BIT];
		enable_vec[`UHIC_SRC_T1024]  = global_irq_mask_reg[`UHIC_G_T1024_BIT];
		enable_vec[`UHIC_SRC_A0]     = endpoint_irq_mask_reg[`UHIC_E_A0_BIT];
		enable_vec[`UHIC_SRC_A1]     = endpoint_irq_mask_reg[`UHIC_E_A1_BIT];
		enable_vec[`UHIC_SRC_A2]     = endpoint_irq_mask_reg[`UHIC_E_A2_BIT];
		enable_vec[`UHIC_SRC_B0]     = endpoint_irq_mask_reg[`UHIC_E_B0_BIT];
		enable_vec[`UHIC_SRC_B1]     = endpoint_irq_mask_reg[`UHIC_E_B1_BIT];
		enable_vec[`UHIC_SRC_HUB]    = global_irq_mask_reg[`UHIC_G_HUB_BIT];
		enable_vec[`UHIC_SRC_CONV]   = aux_irq_mask_reg[`UHIC_A_CONV_BIT];
		enable_vec[`UHIC_SRC_GPIO]   = global_irq_mask_reg[`UHIC_G_GPIO_BIT];
		enable_vec[`UHIC_SRC_SERIAL] = global_irq_mask_reg[`UHIC_G_SERIAL_BIT];
	end

	// One pending latch per source
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++)
		begin : g_latch
			uhic_pend_latch u_latch
			(
				.clk_i  (clk_i),
				.nrst_i (nrst_i),
				.set_i  (src_event_i[gi]),
				.clr_i  (clr_vec[gi]),
				.pend_o (pend_vec[gi])
			);
		end
	endgenerate

	// Masked requests; masking hides a latch but never clears it
	assign req_vec = pend_vec & enable_vec;
	assign any_req = |req_vec;

	// Take a request only at an instruction boundary with global enable set
	assign take = (state_reg == uhic_pkg::UHIC_RUN) && instr_done_i
		&& global_en_reg && any_req;

	// Fixed priority encoder: lowest index wins, vector from index
	always_comb
	begin
		win_vec     = '0;
		vector_next = `UHIC_RESET_VEC;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (req_vec[i])
			begin
				win_vec     = '0;
				win_vec[i]  = 1'b1;
				vector_next = 16'(`UHIC_RESET_VEC + `UHIC_VEC_STEP * 16'(i + 1));
			end
		end
	end

	// Clear only the served latch
	assign clr_vec = take ? win_vec : '0;

	// Sequencer: one boot cycle after reset, then run
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			uhic_pkg::UHIC_BOOT:
				state_next = uhic_pkg::UHIC_RUN;
			uhic_pkg::UHIC_RUN:
				state_next = uhic_pkg::UHIC_RUN;
			default:
				state_next = uhic_pkg::UHIC_BOOT;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state_reg <= uhic_pkg::UHIC_BOOT;
		else
			state_reg <= state_next;
	end

	// Global enable: acknowledge clears; return and unmask set; mask clears
	always_comb
	begin
		global_en_next = global_en_reg;
		if (take)
			global_en_next = 1'b0;
		else if (irq_return_op_i)
			global_en_next = 1'b1;
		else if (unmask_all_irq_op_i)
			global_en_next = 1'b1;
		else if (mask_all_irq_op_i)
			global_en_next = 1'b0;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			global_en_reg <= 1'b0;
		else
			global_en_reg <= global_en_next;
	end

	// Boot pulse announcing the reset entry point
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			boot_reg <= 1'b0;
		else
			boot_reg <= (state_reg == uhic_pkg::UHIC_BOOT);
	end

	// Automatic call pulse and its target address
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			call_reg   <= 1'b0;
			vector_reg <= `UHIC_RESET_VEC;
		end
		else
		begin
			call_reg <= take;
			if (take)
				vector_reg <= vector_next;
			else if (state_reg == uhic_pkg::UHIC_BOOT)
				vector_reg <= `UHIC_RESET_VEC;
		end
	end

	// Context pushed by the call: program counter and flags only
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			push_frame_reg <= '0;
		else if (take)
			push_frame_reg <= cpu_frame_i;
	end

	// Return: hand the popped context back to the core
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			restore_reg       <= 1'b0;
			restore_frame_reg <= '0;
		end
		else
		begin
			restore_reg <= irq_return_op_i;
			if (irq_return_op_i)
				restore_frame_reg <= stack_frame_i;
		end
	end

	// Pending sense: any enabled latch after this cycle's clear and set
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			pending_reg <= 1'b0;
		else
			pending_reg <= |(((pend_vec & ~clr_vec) | src_event_i) & enable_vec);
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = `UHIC_RDATA_RST;
		case (reg_addr_i)
			`UHIC_GMASK_OFS:
				rdata_next = global_irq_mask_reg;
			`UHIC_EMASK_OFS:
				rdata_next = endpoint_irq_mask_reg;
			`UHIC_AMASK_OFS:
				rdata_next = aux_irq_mask_reg;
			`UHIC_PSTAT_OFS:
			begin
				rdata_next[`UHIC_PSTAT_PEND_BIT] = pending_reg;
				rdata_next[`UHIC_PSTAT_SENS_BIT] = global_en_reg;
			end
			default:
				rdata_next = `UHIC_RDATA_RST;
		endcase
	end

	// Read data register, valid the cycle after the strobe
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_reg <= `UHIC_RDATA_RST;
		else if (reg_rd_i)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= `UHIC_RDATA_RST;
	end

	// Outputs
	assign reg_rdata_o     = rdata_reg;
	assign boot_start_o    = boot_reg;
	assign irq_call_o      = call_reg;
	assign irq_vector_o    = vector_reg;
	assign push_frame_o    = push_frame_reg;
	assign restore_o       = restore_reg;
	assign restore_frame_o = restore_frame_reg;
	assign global_irq_en_o = global_en_reg;
	assign irq_pending_o   = pending_reg;

endmodule
`default_nettype wire

// *** verification/uhic_cpu_model.sv ***
// Processor core stand-in: instruction boundaries and context
`timescale 1ns/1ps
`default_nettype none
module uhic_cpu_model
(
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             slow_i,
	output logic                  instr_done_o,
	output uhic_pkg::uhic_frame_s frame_o
);
	logic [1:0] phase_reg;
	// Instruction phase, three cycles long when slow
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			phase_reg <= 2'h0;
		else
			phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
	end
	// Boundary every cycle, or every third
	assign instr_done_o = !slow_i || (phase_reg == 2'h2);
	// Context moves on at each boundary
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			frame_o <= '0;
		else if (instr_done_o)
			frame_o <= uhic_pkg::uhic_frame_s'(frame_o + 18'h00005);
	end
endmodule
`default_nettype wire

// *** verification/uhic_irq_ctrl_chk.sv ***
// Port assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module uhic_irq_ctrl_chk
(
	input wire logic                  clk_i,
	input wire logic                  nrst_i,
	input wire logic                  instr_done_i,
	input wire logic                  unmask_all_irq_op_i,
	input wire logic                  irq_return_op_i,
	input wire uhic_pkg::uhic_frame_s cpu_frame_i,
	input wire uhic_pkg::uhic_frame_s stack_frame_i,
	input wire logic                  boot_start_o,
	input wire logic                  irq_call_o,
	input wire logic [15:0]           irq_vector_o,
	input wire uhic_pkg::uhic_frame_s push_frame_o,
	input wire logic                  restore_o,
	input wire uhic_pkg::uhic_frame_s restore_frame_o,
	input wire logic                  global_irq_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_call_single: assert property (irq_call_o |=> !irq_call_o)
		else $error("call pulse too long");
	a_take_gated: assert property (irq_call_o |-> $past(instr_done_i) && $past(global_irq_en_o))
		else $error("take off boundary or disabled");
	a_take_clears: assert property (irq_call_o |-> !global_irq_en_o)
		else $error("enable kept on take");
	a_vector_slot: assert property (irq_call_o |-> !irq_vector_o[0] && irq_vector_o >= 16'h0002
		&& irq_vector_o <= 16'h0018)
		else $error("vector off table");
	a_push_frame: assert property (irq_call_o |-> push_frame_o == $past(cpu_frame_i))
		else $error("pushed context wrong");
	a_gie_rise: assert property ($rose(global_irq_en_o) |-> $past(unmask_all_irq_op_i)
		|| $past(irq_return_op_i))
		else $error("enable rose without op");
	a_return_seq: assert property (irq_return_op_i && !global_irq_en_o |=> restore_o
		&& global_irq_en_o ##1 !restore_o)
		else $error("return not restored");
	a_restore_frame: assert property (restore_o |-> restore_frame_o == $past(stack_frame_i))
		else $error("restored context wrong");
	a_boot_vector: assert property (boot_start_o |-> irq_vector_o == 16'h0000 ##1 !boot_start_o)
		else $error("boot entry wrong");
endmodule
bind uhic_irq_ctrl uhic_irq_ctrl_chk u_chk (.clk_i, .nrst_i, .instr_done_i, .unmask_all_irq_op_i,
	.irq_return_op_i, .cpu_frame_i, .stack_frame_i, .boot_start_o, .irq_call_o, .irq_vector_o,
	.push_frame_o, .restore_o, .restore_frame_o, .global_irq_en_o);
`default_nettype wire

// *** verification/usb_hub_mcu_interrupt_ctrl_bench.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module usb_hub_mcu_interrupt_ctrl_bench;
	logic                  clk, nrst, wr, rd, done, ei, di, ret, slow;
	logic                  boot, call, rest, gie, pend;
	logic [7:0]            addr, wdata, rdata, d;
	logic [11:0]           ev;
	logic [15:0]           vec;
	uhic_pkg::uhic_frame_s cframe, sframe;
	int                    fails, samples_checked;
	logic [23:0]           rows [6] = '{24'h20FF6F, 24'h21FF1F, 24'h22FF01, 24'h30FF00,
		24'hFFFF00, 24'h20A828};
	uhic_irq_ctrl dut (.clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .src_event_i(ev),
		.instr_done_i(done), .unmask_all_irq_op_i(ei), .mask_all_irq_op_i(di),
		.irq_return_op_i(ret), .cpu_frame_i(cframe), .stack_frame_i(sframe),
		.boot_start_o(boot), .irq_call_o(call), .irq_vector_o(vec), .push_frame_o(),
		.restore_o(rest), .restore_frame_o(), .global_irq_en_o(gie), .irq_pending_o(pend));
	uhic_cpu_model cpu (.clk_i(clk), .nrst_i(nrst), .slow_i(slow), .instr_done_o(done),
		.frame_o(cframe));
	// Compare and count
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Register write and read cycles
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 1'b0;
		#1 v = rdata;
	endtask
	// Reset and boot entry
	task automatic rst();
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1 chk(boot, 1'b1);
		chk(vec, 16'h0000);
	endtask
	// Wait boundedly for a call
	task automatic wait_call();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end
		while (call !== 1'b1 && n < 20);
		chk(call, 1'b1);
	endtask
	task automatic complete_run();
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		#100000 fails++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		{nrst, wr, rd, ei, di, ret, slow, addr, wdata, ev} = '0;
		sframe = 18'h2A5A5;
		rst();
		foreach (rows[i])
		begin
			wreg(rows[i][23:16], rows[i][15:8]);
			rreg(rows[i][23:16], d);
			chk(d, rows[i][7:0]);
		end
		rst();
		rreg(8'h20, d);
		chk(d, 8'h00);
		wreg(8'h20, 8'h6F);
		wreg(8'h21, 8'h1F);
		wreg(8'h22, 8'h01);
		@(posedge clk) {ev, slow} <= {12'hFFF, 1'b1};
		@(posedge clk) ev <= 12'h000;
		rreg(8'hFF, d);
		chk(d, 8'h80);
		chk(call, 1'b0);
		// Every mask off: the held latches must stop requesting
		wreg(8'h20, 8'h00);
		wreg(8'h21, 8'h00);
		wreg(8'h22, 8'h00);
		@(posedge clk);
		#1 chk(pend, 1'b0);
		wreg(8'h20, 8'h6F);
		wreg(8'h21, 8'h1F);
		wreg(8'h22, 8'h01);
		@(posedge clk) di <= 1'b1;
		@(posedge clk) di <= 1'b0;
		#1 chk(pend, 1'b1);
		rreg(8'h20, d);
		chk(d, 8'h6F);
		@(posedge clk) ei <= 1'b1;
		@(posedge clk) ei <= 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			wait_call();
			chk(vec, 16'h0002 + 16'(2 * i));
			chk(pend, 1'(i < 11));
			@(posedge clk) {ei, ret} <= {i[0], !i[0]};
			@(posedge clk) {ei, ret} <= 2'b00;
			#1 chk(gie, 1'b1);
			chk(rest, !i[0]);
		end
		// Enable sense reads back, disable clears only the global enable
		rreg(8'hFF, d);
		chk(d, 8'h04);
		@(posedge clk) di <= 1'b1;
		@(posedge clk) di <= 1'b0;
		#1 chk(gie, 1'b0);
		rreg(8'h21, d);
		chk(d, 8'h1F);
		// Event in the clearing cycle keeps its latch pending
		@(posedge clk) {ev, ei, slow} <= {12'h001, 1'b1, 1'b0};
		@(posedge clk) ei <= 1'b0;
		@(posedge clk) ev <= 12'h000;
		#1 chk(call, 1'b1);
		chk(pend, 1'b1);
		@(posedge clk) ret <= 1'b1;
		@(posedge clk) ret <= 1'b0;
		wait_call();
		chk(vec, 16'h0002);
		complete_run();
	end
endmodule
`default_nettype wire
